// [dv/picl_ee_model.sv]
// Purpose: serial memory holding the init word
// Assumes: device drives clock and command
// Notes:   shifts stored word msb first
`timescale 1ns/1ps
`default_nettype none
module picl_ee_model (
  input  wire logic        sclk,
  input  wire logic        sclkOe,
  input  wire logic        addrIn,
  input  wire logic [15:0] mem,
  output var  logic        dOut,
  output var  logic [8:0]  cmd
);
  int edgeCnt;
  initial dOut = 1'b0;
  always @(posedge sclk or negedge sclkOe) begin
    if (!sclkOe) begin
      edgeCnt <= 0;
      dOut    <= ~dOut;
    end else begin
      edgeCnt <= edgeCnt + 1;
      if (edgeCnt < 9) cmd <= {cmd[7:0], addrIn};
      else if (edgeCnt < 25) dOut <= mem[24-edgeCnt];
      else dOut <= ~dOut;
    end
  end
endmodule : picl_ee_model
`default_nettype wire

// [dv/picl_props.sv]
// Purpose: assertions on the loader ports
// Assumes: one clock, rst synchronous high
// Notes:   bound to picl_top below
`timescale 1ns/1ps
`default_nettype none
module picl_props
  import picl_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           cfgModeSelHiZ,
  input wire logic           cfgSerialClkOe,
  input wire picl_mgmt_req_t mgmtReq,
  input wire picl_mgmt_rsp_t mgmtRsp,
  input wire logic [15:0]    initWord,
  input wire logic           initLoaded,
  input wire picl_phy_ctrl_t phyCtrl
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_word_locked: assert property (initLoaded |=> initLoaded && $stable(initWord))
    else $error("init word moved");
  a_word_default: assert property (!initLoaded |-> initWord == INIT_DEFAULT)
    else $error("word before load");
  a_clk_dir: assert property (!cfgModeSelHiZ |-> !cfgSerialClkOe)
    else $error("clock driven off memory mode");
  a_own_addr: assert property (mgmtRsp.rdValid |-> $past(mgmtReq.phyAddr) == $past(initWord[15:11]))
    else $error("foreign address answered");
  a_iso_off: assert property (initWord[7] |-> !phyCtrl.isolateMii)
    else $error("isolate not disabled");
  a_rep_half: assert property (initWord[6] |-> !phyCtrl.fullDuplex && phyCtrl.crsRxOnly)
    else $error("repeater not half duplex");
  a_restart_cause: assert property (phyCtrl.anegRestart |-> $past(mgmtReq.write) && $past(mgmtReq.wrData[9]))
    else $error("restart without write");
  a_reset_bit: assert property (mgmtRsp.hit && $past(mgmtReq.write) && $past(mgmtReq.wrData[15])
    |-> phyCtrl.anegEnable && phyCtrl.speed100 && !phyCtrl.loopback)
    else $error("control reset failed");
endmodule : picl_props
bind picl_top picl_props i_props (.sys_clk(sys_clk), .rst(rst), .cfgModeSelHiZ(cfgModeSelHiZ),
  .cfgSerialClkOe(cfgSerialClkOe), .mgmtReq(mgmtReq), .mgmtRsp(mgmtRsp), .initWord(initWord),
  .initLoaded(initLoaded), .phyCtrl(phyCtrl));
`default_nettype wire

// [dv/test_picl_top.sv]
// Purpose: self-checking bench of the loader
// Assumes: 20 MHz clock, rst as power-up
// Notes:   one power-up per mode
`timescale 1ns/1ps
`default_nettype none
module test_picl_top;
  import picl_pkg::*;
  localparam logic [15:0] WM = 16'h28c0;
  localparam logic [15:0] WE = 16'h0b25;
  logic sys_clk, rst, hz, lv, tbClk, tbDat, half, rv, ht, rs;
  picl_mgmt_req_t req;
  picl_mgmt_rsp_t rsp;
  picl_phy_ctrl_t ctl;
  logic [15:0] word, rd;
  logic mOut, mOe, cOut, cOe, eeDat, ld, sH, sF, sT;
  logic [8:0] cmd;
  int err_total, n_tests;
  wire logic modeIn = mOe ? mOut : lv;
  wire logic clkIn = cOe ? cOut : tbClk;
  wire logic datIn = hz ? eeDat : tbDat;
  picl_top i_picl_top (.sys_clk(sys_clk), .rst(rst), .cfgModeSelIn(modeIn), .cfgModeSelHiZ(hz),
    .cfgModeSelOut(mOut), .cfgModeSelOe(mOe), .cfgSerialClkIn(clkIn), .cfgSerialClkOut(cOut),
    .cfgSerialClkOe(cOe), .cfgSerialDataIn(datIn), .strapTenHalf(half), .mgmtReq(req), .mgmtRsp(rsp),
    .initWord(word), .initLoaded(ld), .statT4Cap(sT), .statTenFullCap(sF), .statTenHalfCap(sH), .phyCtrl(ctl));
  // stored image is the word bit-reversed
  picl_ee_model i_picl_ee_model (.sclk(cOut), .sclkOe(cOe), .addrIn(mOut), .mem(16'ha4d0), .dOut(eeDat), .cmd(cmd));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic pu(input logic h, l, s);
    rst <= 1'b1;
    hz <= h;
    lv <= l;
    half <= s;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pu
  task automatic mg(input logic w, input logic [4:0] p, r, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{read: !w, write: w, phyAddr: p, regAddr: r, wrData: d};
    @(posedge sys_clk);
    req.read <= 1'b0;
    req.write <= 1'b0;
    #1;
    {rv, ht, rd, rs} = {rsp.rdValid, rsp.hit, rsp.rdData, ctl.anegRestart};
    @(posedge sys_clk);
  endtask : mg
  task automatic sb(input logic b);
    tbDat <= b;
    repeat (5) @(posedge sys_clk);
    tbClk <= 1'b1;
    repeat (5) @(posedge sys_clk);
    tbClk <= 1'b0;
  endtask : sb
  task automatic t_hw;
    tbDat <= 1'b1;
    pu(1'b0, 1'b0, 1'b1);
    chk({ld, sH, sF, sT, word}, 20'hd0500);
    {tbDat, half} <= 2'b00;
    mg(0, 0, 0, 0);
    chk({rv, ht, rd}, 18'h33400);
    chk({ctl.isolateMii, ctl.anegEnable, ctl.speed100, ctl.fullDuplex, ctl.loopback}, 5'b11100);
    mg(0, 1, 0, 0);
    chk(rv, 0);
    mg(0, 0, 1, 0);
    chk({rv, ht, rd}, 18'h20000);
    chk(word, 16'h0500);
    $display("t_hw done");
  endtask : t_hw
  task automatic t_ctrl;
    mg(1, 0, 0, 16'h4980);
    chk({ht, ctl.loopback, ctl.speed100, ctl.anegEnable, ctl.isolateMii, ctl.fullDuplex, ctl.colTest,
         ctl.powerDown}, 8'hc7);
    mg(0, 0, 0, 0);
    chk(rd, 16'h4980);
    mg(1, 0, 0, 16'h2200);
    chk({rs, ctl.speed100}, 2'b11);
    mg(0, 0, 0, 0);
    chk(rd, 16'h2000);
    mg(1, 1, 0, 16'h4000);
    chk({ht, ctl.loopback}, 0);
    mg(1, 0, 0, 16'hc000);
    mg(0, 0, 0, 0);
    chk(rd, CTRL_DEFAULT);
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_micro;
    tbDat <= 1'b0;
    pu(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 15; i++) sb(WM[i]);
    chk({ld, word}, 0);
    sb(WM[15]);
    repeat (5) @(posedge sys_clk);
    chk({ld, sH, ctl.isolateMii, word}, {3'b100, WM});
    for (int i = 0; i < 3; i++) sb(1'b1);
    mg(0, 0, 0, 0);
    chk({rv, word}, WM);
    mg(1, 5, 0, 16'h0100);
    chk({ht, ctl.fullDuplex, ctl.crsRxOnly}, 3'b101);
    $display("t_micro done");
  endtask : t_micro
  task automatic t_ee;
    pu(1'b1, 1'b1, 1'b0);
    chk({cOe, mOe, mOut}, 3'b111);
    for (int i = 0; i < 3000 && !ld; i++) @(posedge sys_clk);
    chk({ld, cOe, mOe, sH, sF, sT, word}, {6'b100011, WE});
    chk(cmd, EE_READ_CMD);
    $display("t_ee done");
  endtask : t_ee
  initial begin
    tbClk = 1'b0;
    req = '0;
    err_total = 0;
    n_tests = 0;
    t_hw();
    t_ctrl();
    t_micro();
    t_ee();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
endmodule : test_picl_top
`default_nettype wire

// [src/picl_pkg.sv]
// Purpose: shared constants and types of the power-up configuration loader
// Assumes: 20 MHz system clock
// Notes:   init word and basic control register layouts
package picl_pkg;

  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int EE_CLK_HALF_NS    = 1000;
  localparam int EE_HALF_CYCLES    = (EE_CLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [4:0] EE_HALF_LAST = 5'(EE_HALF_CYCLES - 1);

  localparam int INIT_BITS = 16;
  localparam logic [4:0] INIT_LAST_BIT = 5'h10;

  // serial memory read: start bit, read opcode, six address bits
  localparam int EE_CMD_BITS = 9;
  localparam logic [EE_CMD_BITS-1:0] EE_READ_CMD = 9'h180;
  localparam logic [4:0] EE_FIRST_DATA_EDGE = 5'h0a;
  localparam logic [4:0] EE_LAST_DATA_EDGE  = 5'h19;

  localparam logic [1:0] SETTLE_LAST = 2'h3;

  // init word fields
  localparam int INIT_ADDR_MSB   = 15;
  localparam int INIT_ADDR_LSB   = 11;
  localparam int INIT_TEN_HALF   = 10;
  localparam int INIT_TEN_FULL   = 9;
  localparam int INIT_T4         = 8;
  localparam int INIT_ISO_DIS    = 7;
  localparam int INIT_REPEATER   = 6;
  localparam logic [15:0] INIT_DEFAULT = 16'h0000;
  localparam logic [4:0]  HARDWIRED_PHY_ADDR = 5'h00;

  // basic control register
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam int CTRL_RESET      = 15;
  localparam int CTRL_LOOPBACK   = 14;
  localparam int CTRL_SPEED100   = 13;
  localparam int CTRL_ANEG_EN    = 12;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_ISOLATE    = 10;
  localparam int CTRL_ANEG_RST   = 9;
  localparam int CTRL_DUPLEX     = 8;
  localparam int CTRL_COL_TEST   = 7;
  localparam logic [15:0] CTRL_DEFAULT = 16'h3400;
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7d80;

  typedef enum logic [3:0] {
    ST_SETTLE = 4'h1,
    ST_EEPROM = 4'h2,
    ST_MICRO  = 4'h4,
    ST_DONE   = 4'h8
  } picl_state_t;

  typedef enum logic [1:0] {
    MODE_HARDWIRED = 2'h0,
    MODE_MICRO     = 2'h1,
    MODE_EEPROM    = 2'h2
  } picl_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  phyAddr;
    logic [4:0]  regAddr;
    logic [15:0] wrData;
  } picl_mgmt_req_t;

  typedef struct packed {
    logic        rdValid;
    logic        hit;
    logic [15:0] rdData;
  } picl_mgmt_rsp_t;

  typedef struct packed {
    logic loopback;
    logic speed100;
    logic anegEnable;
    logic powerDown;
    logic isolateMii;
    logic anegRestart;
    logic fullDuplex;
    logic colTest;
    logic crsRxOnly;
  } picl_phy_ctrl_t;

endpackage : picl_pkg

// [src/picl_sync.sv]
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single system clock, synchronous reset
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module picl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } picl_sync_st_t;

  picl_sync_st_t cur_ff;
  picl_sync_st_t nxt_cur;

  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.meta   = asyncIn;
    nxt_cur.stable = cur_ff.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign syncOut = cur_ff.stable;

endmodule : picl_sync
`default_nettype wire

// [src/picl_top.sv]
// Purpose: power-up configuration loader and basic control register of the PHY
// Assumes: rst is the power-up reset; 20 MHz sys_clk
// Notes:   management frame decoding sits outside; this block sees decoded requests
`timescale 1ns/1ps
`default_nettype none
module picl_top
  import picl_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            cfgModeSelIn,
  input  wire logic            cfgModeSelHiZ,
  output logic                 cfgModeSelOut,
  output logic                 cfgModeSelOe,
  input  wire logic            cfgSerialClkIn,
  output logic                 cfgSerialClkOut,
  output logic                 cfgSerialClkOe,
  input  wire logic            cfgSerialDataIn,
  input  wire logic            strapTenHalf,
  input  wire picl_mgmt_req_t  mgmtReq,
  output picl_mgmt_rsp_t       mgmtRsp,
  output logic [15:0]          initWord,
  output logic                 initLoaded,
  output logic                 statT4Cap,
  output logic                 statTenFullCap,
  output logic                 statTenHalfCap,
  output picl_phy_ctrl_t       phyCtrl
);

  typedef struct packed {
    picl_state_t     state;
    picl_mode_t      mode;
    logic [1:0]      settle;
    logic [4:0]      tick;
    logic [4:0]      bitCnt;
    logic [EE_CMD_BITS-1:0] cmdSh;
    logic            sclk;
    logic            addrOut;
    logic            addrOe;
    logic            sclkOe;
    logic            clkPrev;
    logic [15:0]     shift;
    logic [15:0]     init;
    logic            loaded;
    logic [15:0]     ctrl;
    logic            anegRestart;
    picl_mgmt_rsp_t  rsp;
  } picl_top_st_t;

  picl_top_st_t cur_ff;
  picl_top_st_t nxt_cur;

  logic [4:0] pinSync;
  logic       modeSelLvl;
  logic       modeSelHiZ;
  logic       serClk;
  logic       serData;
  logic       tenHalf;
  logic       addrMatch;
  logic [4:0] ownAddr;

  picl_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({cfgModeSelIn, cfgModeSelHiZ, cfgSerialClkIn, cfgSerialDataIn, strapTenHalf}),
    .syncOut (pinSync)
  );

  assign modeSelLvl = pinSync[4];
  assign modeSelHiZ = pinSync[3];
  assign serClk     = pinSync[2];
  assign serData    = pinSync[1];
  assign tenHalf    = pinSync[0];

  // hardwired mode answers only address zero; otherwise the loaded address
  assign ownAddr   = (cur_ff.mode == MODE_HARDWIRED) ? HARDWIRED_PHY_ADDR
                   : cur_ff.init[INIT_ADDR_MSB:INIT_ADDR_LSB];
  assign addrMatch = (mgmtReq.phyAddr == ownAddr);

  always_comb begin
    nxt_cur             = cur_ff;
    nxt_cur.anegRestart = 1'b0;
    nxt_cur.rsp.rdValid = 1'b0;
    nxt_cur.rsp.hit     = 1'b0;

    case (cur_ff.state)
      ST_SETTLE: begin
        // wait for the synchronisers to fill, then catch the mode pin once
        nxt_cur.settle = cur_ff.settle + 2'h1;
        if (cur_ff.settle == SETTLE_LAST) begin
          if (modeSelHiZ) begin
            nxt_cur.mode    = MODE_EEPROM;
            nxt_cur.state   = ST_EEPROM;
            nxt_cur.addrOe  = 1'b1;
            nxt_cur.sclkOe  = 1'b1;
            nxt_cur.cmdSh   = EE_READ_CMD;
            nxt_cur.addrOut = EE_READ_CMD[EE_CMD_BITS-1];
          end else if (modeSelLvl) begin
            nxt_cur.mode    = MODE_MICRO;
            nxt_cur.state   = ST_MICRO;
            nxt_cur.clkPrev = serClk;
          end else begin
            nxt_cur.mode  = MODE_HARDWIRED;
            nxt_cur.state = ST_DONE;
            nxt_cur.loaded = 1'b1;
            nxt_cur.init[INIT_TEN_HALF] = tenHalf;
            nxt_cur.init[INIT_TEN_FULL] = serClk;
            nxt_cur.init[INIT_T4]       = serData;
          end
        end
      end

      ST_EEPROM: begin
        nxt_cur.tick = cur_ff.tick + 5'h01;
        if (cur_ff.tick == EE_HALF_LAST) begin
          nxt_cur.tick = '0;
          if (!cur_ff.sclk) begin
            nxt_cur.sclk   = 1'b1;
            nxt_cur.bitCnt = cur_ff.bitCnt + 5'h01;
          end else begin
            nxt_cur.sclk    = 1'b0;
            nxt_cur.cmdSh   = {cur_ff.cmdSh[EE_CMD_BITS-2:0], 1'b0};
            nxt_cur.addrOut = cur_ff.cmdSh[EE_CMD_BITS-2];
            if (cur_ff.bitCnt >= EE_FIRST_DATA_EDGE) begin
              nxt_cur.shift = {serData, cur_ff.shift[15:1]};
            end
            if (cur_ff.bitCnt == EE_LAST_DATA_EDGE) begin
              nxt_cur.init    = {serData, cur_ff.shift[15:1]};
              nxt_cur.loaded  = 1'b1;
              nxt_cur.state   = ST_DONE;
              nxt_cur.addrOe  = 1'b0;
              nxt_cur.sclkOe  = 1'b0;
              nxt_cur.addrOut = 1'b0;
            end
          end
        end
      end

      ST_MICRO: begin
        // only this device's clock toggles when it is being programmed
        nxt_cur.clkPrev = serClk;
        if (serClk && !cur_ff.clkPrev) begin
          nxt_cur.shift  = {serData, cur_ff.shift[15:1]};
          nxt_cur.bitCnt = cur_ff.bitCnt + 5'h01;
          if (cur_ff.bitCnt == INIT_LAST_BIT - 5'h01) begin
            nxt_cur.init   = {serData, cur_ff.shift[15:1]};
            nxt_cur.loaded = 1'b1;
            nxt_cur.state  = ST_DONE;
          end
        end
      end

      ST_DONE: begin
        nxt_cur.state = ST_DONE;
      end

      default: begin
        nxt_cur.state = ST_SETTLE;
      end
    endcase

    // management access to the basic control register
    if (mgmtReq.write && addrMatch) begin
      if (mgmtReq.regAddr == REG_BASIC_CONTROL) begin
        nxt_cur.rsp.hit = 1'b1;
        if (mgmtReq.wrData[CTRL_RESET]) begin
          nxt_cur.ctrl = CTRL_DEFAULT;
        end else begin
          nxt_cur.ctrl = mgmtReq.wrData & CTRL_STORE_MASK;
          nxt_cur.anegRestart = mgmtReq.wrData[CTRL_ANEG_RST];
        end
      end
    end else if (mgmtReq.read && addrMatch) begin
      nxt_cur.rsp.rdValid = 1'b1;
      if (mgmtReq.regAddr == REG_BASIC_CONTROL) begin
        nxt_cur.rsp.hit    = 1'b1;
        nxt_cur.rsp.rdData = cur_ff.ctrl;
      end else begin
        nxt_cur.rsp.rdData = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur_ff             <= '0;
      cur_ff.state       <= ST_SETTLE;
      cur_ff.mode        <= MODE_HARDWIRED;
      cur_ff.cmdSh       <= EE_READ_CMD;
      cur_ff.init        <= INIT_DEFAULT;
      cur_ff.ctrl        <= CTRL_DEFAULT;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cfgModeSelOut   = cur_ff.addrOut;
  assign cfgModeSelOe    = cur_ff.addrOe;
  assign cfgSerialClkOut = cur_ff.sclk;
  assign cfgSerialClkOe  = cur_ff.sclkOe;
  assign mgmtRsp         = cur_ff.rsp;
  assign initWord        = cur_ff.init;
  assign initLoaded      = cur_ff.loaded;

  assign statT4Cap      = cur_ff.init[INIT_T4];
  assign statTenFullCap = cur_ff.init[INIT_TEN_FULL];
  assign statTenHalfCap = cur_ff.init[INIT_TEN_HALF];

  always_comb begin
    phyCtrl.loopback    = cur_ff.ctrl[CTRL_LOOPBACK];
    phyCtrl.anegEnable  = cur_ff.ctrl[CTRL_ANEG_EN];
    phyCtrl.speed100    = cur_ff.ctrl[CTRL_ANEG_EN] | cur_ff.ctrl[CTRL_SPEED100];
    phyCtrl.powerDown   = cur_ff.ctrl[CTRL_POWER_DOWN];
    phyCtrl.isolateMii  = cur_ff.ctrl[CTRL_ISOLATE] & ~cur_ff.init[INIT_ISO_DIS];
    phyCtrl.anegRestart = cur_ff.anegRestart;
    phyCtrl.fullDuplex  = ~cur_ff.ctrl[CTRL_ANEG_EN] & cur_ff.ctrl[CTRL_DUPLEX]
                          & ~cur_ff.init[INIT_REPEATER];
    phyCtrl.colTest     = cur_ff.ctrl[CTRL_COL_TEST];
    phyCtrl.crsRxOnly   = cur_ff.init[INIT_REPEATER];
  end

endmodule : picl_top
`default_nettype wire
